// ### rtl/rdseq_pkg.sv
package rdseq_pkg;
  // clock rate
  localparam int unsigned CLK_HZ         = 125_000_000;
  // delay counter width and program memory top
  localparam int unsigned DLY_BITS       = 10;
  localparam logic [11:0] PC_TOP         = 12'hFFF;
  // timeouts: power-on in microseconds, wake delays in units of 0.1 us
  localparam int unsigned POR_US         = 72_000;
  localparam int unsigned WAKE00_US10    = 600;     // 0.06 ms in units of 0.1 us
  localparam int unsigned WAKE01_US10    = 184_000; // 18.4 ms
  localparam int unsigned WAKE10_US10    = 600_000; // 60 ms
  localparam int unsigned WAKE11_US10    = 9_600_000; // 960 ms
  // clock cycles per microsecond
  localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;
  // reset-source-flag codes {timeout_flag, powerdown_flag}
  localparam logic [1:0]  FLAGS_POR      = 2'h3;
  localparam logic [1:0]  FLAGS_WDT_PD   = 2'h0;
  localparam logic [1:0]  FLAGS_WDT_ACT  = 2'h1;
  localparam logic [1:0]  FLAGS_PIN_PD   = 2'h2;
  // wake delay codes
  localparam logic [1:0]  WAKE_DEFAULT   = 2'h1;
  // brown-out level codes
  localparam logic [1:0]  BOR_2V2        = 2'h0;
  localparam logic [1:0]  BOR_2V6        = 2'h1;
  localparam logic [1:0]  BOR_4V2        = 2'h2;
  typedef enum logic [2:0] {
    RDSEQ_HOLD = 3'b001,
    RDSEQ_WAIT = 3'b010,
    RDSEQ_RUN  = 3'b100
  } rdseq_state_type;
endpackage

// ### rtl/rdseq_top.sv
`timescale 1ns/10ps
module rdseq_top #(
  parameter int unsigned POR_CYCLES = rdseq_pkg::POR_US * (rdseq_pkg::CLK_HZ / 1_000_000),
  parameter int unsigned W00_CYCLES = rdseq_pkg::WAKE00_US10 * rdseq_pkg::CLK_MHZ / 10,
  parameter int unsigned W01_CYCLES = rdseq_pkg::WAKE01_US10 * rdseq_pkg::CLK_MHZ / 10,
  parameter int unsigned W10_CYCLES = rdseq_pkg::WAKE10_US10 * rdseq_pkg::CLK_MHZ / 10,
  parameter int unsigned W11_CYCLES = rdseq_pkg::WAKE11_US10 * rdseq_pkg::CLK_MHZ / 10
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        power_on_event,
  input  wire logic        external_reset_pin,
  input  wire logic        watchdog_event,
  input  wire logic        wakeup_event,
  input  wire logic        in_powerdown,
  input  wire logic [2:0]  supply_above_level,
  input  wire logic [1:0]  brownout_level_select,
  input  wire logic        brownout_enable,
  input  wire logic [1:0]  wake_delay_select,
  input  wire logic        sleep_clock_off_bit,
  output logic             internal_reset,
  output logic             pc_load,
  output logic [11:0]      pc_value,
  output logic             timeout_flag,
  output logic             powerdown_flag,
  output logic             sleep_clock_run
);
  import rdseq_pkg::*;

  localparam int unsigned STEP_POR = (POR_CYCLES + (1 << DLY_BITS) - 1) >> DLY_BITS;
  localparam int unsigned STEP_W00 = (W00_CYCLES + (1 << DLY_BITS) - 1) >> DLY_BITS;
  localparam int unsigned STEP_W01 = (W01_CYCLES + (1 << DLY_BITS) - 1) >> DLY_BITS;
  localparam int unsigned STEP_W10 = (W10_CYCLES + (1 << DLY_BITS) - 1) >> DLY_BITS;
  localparam int unsigned STEP_W11 = (W11_CYCLES + (1 << DLY_BITS) - 1) >> DLY_BITS;
  localparam logic [DLY_BITS-1:0] DLY_MAX = {DLY_BITS{1'b1}};

  // synchronisers for pins and analog detector outputs
  logic [1:0] pin_s1_q, pin_s2_q;
  logic [2:0] sup_s1_q, sup_s2_q;
  logic [1:0] evt_s1_q, evt_s2_q;
  always_ff @(posedge clk) begin
    pin_s1_q <= {power_on_event, external_reset_pin};
    pin_s2_q <= pin_s1_q;
    sup_s1_q <= supply_above_level;
    sup_s2_q <= sup_s1_q;
    evt_s1_q <= {watchdog_event, wakeup_event};
    evt_s2_q <= evt_s1_q;
  end

  wire por_s  = pin_s2_q[1];
  wire pin_hi = pin_s2_q[0];
  wire wdt_s  = evt_s2_q[1];
  wire wake_s = evt_s2_q[0];

  // brown-out threshold select
  function automatic logic bor_ok(input logic [1:0] sel, input logic [2:0] above);
    unique case (sel)
      BOR_2V2: bor_ok = above[0];
      BOR_2V6: bor_ok = above[1];
      BOR_4V2: bor_ok = above[2];
      default: bor_ok = above[2];
    endcase
  endfunction

  wire supply_ok = !brownout_enable || bor_ok(brownout_level_select, sup_s2_q);
  wire brownout  = !supply_ok;

  logic pin_hi_q;
  logic por_mode_q, por_mode_d;
  always_ff @(posedge clk) begin
    if (rst) pin_hi_q <= 1'b0;
    else     pin_hi_q <= pin_hi;
  end
  wire pin_fall = pin_hi_q && !pin_hi;

  wire any_src = por_s || brownout || wdt_s || wake_s || pin_fall;

  // full count for power-on only, wake delay otherwise
  logic [31:0] step_len;
  always_comb begin
    step_len = STEP_POR;
    if (!por_mode_q) begin
      unique case (wake_delay_select)
        2'h0:    step_len = STEP_W00;
        2'h1:    step_len = STEP_W01;
        2'h2:    step_len = STEP_W10;
        default: step_len = STEP_W11;
      endcase
    end
  end

  rdseq_state_type state_q, state_d;
  logic [DLY_BITS-1:0] dly_q, dly_d;
  logic [31:0] pre_q, pre_d;
  wire step = (pre_q + 32'h1 >= step_len);
  wire done = step && (dly_q == DLY_MAX);

  always_comb begin
    state_d    = state_q;
    dly_d      = dly_q;
    pre_d      = pre_q;
    por_mode_d = por_mode_q;
    if (any_src) begin
      state_d = RDSEQ_HOLD;
      dly_d   = '0;
      pre_d   = '0;
      if (por_s) por_mode_d = 1'b1;
    end else begin
      unique case (state_q)
        RDSEQ_HOLD: if (pin_hi) state_d = RDSEQ_WAIT;
        RDSEQ_WAIT: begin
          pre_d = step ? '0 : pre_q + 32'h1;
          if (step) dly_d = dly_q + 1'b1;
          if (done) begin
            state_d    = RDSEQ_RUN;
            por_mode_d = 1'b0;
          end
        end
        RDSEQ_RUN: ;
        default: state_d = RDSEQ_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= RDSEQ_HOLD;
      dly_q      <= '0;
      pre_q      <= '0;
      por_mode_q <= 1'b1;
    end else begin
      state_q    <= state_d;
      dly_q      <= dly_d;
      pre_q      <= pre_d;
      por_mode_q <= por_mode_d;
    end
  end

  logic [1:0] flags_d;
  always_comb begin
    flags_d = {timeout_flag, powerdown_flag};
    if (por_s)                         flags_d = FLAGS_POR;
    else if (wdt_s)                    flags_d = in_powerdown ? FLAGS_WDT_PD : FLAGS_WDT_ACT;
    else if (pin_fall && in_powerdown) flags_d = FLAGS_PIN_PD;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      internal_reset  <= 1'b1;
      pc_load         <= 1'b1;
      pc_value        <= PC_TOP;
      timeout_flag    <= FLAGS_POR[1];
      powerdown_flag  <= FLAGS_POR[0];
      sleep_clock_run <= 1'b0;
    end else begin
      internal_reset  <= (state_d != RDSEQ_RUN);
      pc_load         <= (state_d != RDSEQ_RUN);
      pc_value        <= PC_TOP;
      {timeout_flag, powerdown_flag} <= flags_d;
      sleep_clock_run <= !sleep_clock_off_bit;
    end
  end

  // helper: cycles spent in wait state
  logic [31:0] wait_cnt_q;
  always_ff @(posedge clk) begin
    if (rst || state_q != RDSEQ_WAIT) wait_cnt_q <= '0;
    else                              wait_cnt_q <= wait_cnt_q + 32'h1;
  end

  property p_src_holds;
    @(posedge clk) disable iff (rst) any_src |=> internal_reset;
  endproperty
  a_src_holds: assert property (p_src_holds) else $error("reset not held after source");

  property p_pc_top;
    @(posedge clk) disable iff (rst) internal_reset |-> pc_load && pc_value == PC_TOP;
  endproperty
  a_pc_top: assert property (p_pc_top) else $error("pc not at top during reset");

  property p_no_count_low;
    @(posedge clk) disable iff (rst) (state_q == RDSEQ_HOLD && !pin_hi) |=> state_q != RDSEQ_WAIT;
  endproperty
  a_no_count_low: assert property (p_no_count_low) else $error("counting with pin low");

  property p_release_time;
    @(posedge clk) disable iff (rst)
      (state_q == RDSEQ_WAIT && state_d == RDSEQ_RUN) |-> wait_cnt_q + 32'h1 == step_len << DLY_BITS;
  endproperty
  a_release_time: assert property (p_release_time) else $error("release time wrong");

  property p_release_clears;
    @(posedge clk) disable iff (rst) (state_q == RDSEQ_RUN && !any_src) |=> !internal_reset;
  endproperty
  a_release_clears: assert property (p_release_clears) else $error("latch not cleared");

  property p_brownout;
    @(posedge clk) disable iff (rst) brownout |=> internal_reset;
  endproperty
  a_brownout: assert property (p_brownout) else $error("reset released during brown-out");

  property p_por_flags;
    @(posedge clk) disable iff (rst) por_s |=> timeout_flag && powerdown_flag;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

  property p_pin_active;
    @(posedge clk) disable iff (rst)
      (pin_fall && !in_powerdown && !por_s && !wdt_s) |=>
        {timeout_flag, powerdown_flag} == $past({timeout_flag, powerdown_flag});
  endproperty
  a_pin_active: assert property (p_pin_active) else $error("pin reset changed flags");

  property p_sleep_clk;
    @(posedge clk) disable iff (rst) !sleep_clock_off_bit |=> sleep_clock_run;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("sleep clock not kept");

  property p_latch_state;
    @(posedge clk) disable iff (rst) internal_reset == (state_q != RDSEQ_RUN);
  endproperty
  a_latch_state: assert property (p_latch_state) else $error("latch out of step");

  property p_dly_start;
    @(posedge clk) disable iff (rst)
      (state_q == RDSEQ_HOLD && state_d == RDSEQ_WAIT) |=> dly_q == '0 && pre_q == '0;
  endproperty
  a_dly_start: assert property (p_dly_start) else $error("count not from zero");

  property p_dly_step;
    @(posedge clk) disable iff (rst)
      (state_q == RDSEQ_WAIT && !any_src && step && !done) |=> dly_q == $past(dly_q) + 1'b1;
  endproperty
  a_dly_step: assert property (p_dly_step) else $error("delay counter skipped");

  property p_pin_low;
    @(posedge clk) disable iff (rst) (!pin_hi && state_q != RDSEQ_RUN) |=> internal_reset;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("released with pin low");

  property p_por_mode;
    @(posedge clk) disable iff (rst) por_s |=> por_mode_q;
  endproperty
  a_por_mode: assert property (p_por_mode) else $error("power-on count not chosen");

  property p_por_len;
    @(posedge clk) disable iff (rst)
      (state_q == RDSEQ_WAIT && por_mode_q) |-> step_len == STEP_POR;
  endproperty
  a_por_len: assert property (p_por_len) else $error("power-on step length wrong");

  property p_wake_fast;
    @(posedge clk) disable iff (rst)
      (!por_mode_q && wake_delay_select == 2'h0) |-> step_len == STEP_W00;
  endproperty
  a_wake_fast: assert property (p_wake_fast) else $error("fast wake length wrong");

  property p_sleep_off;
    @(posedge clk) disable iff (rst) sleep_clock_off_bit |=> !sleep_clock_run;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep clock not stopped");

  property p_supply_back;
    @(posedge clk) disable iff (rst)
      (state_q == RDSEQ_HOLD && pin_hi && !any_src) |=> state_q == RDSEQ_WAIT;
  endproperty
  a_supply_back: assert property (p_supply_back) else $error("no count after recovery");

  property p_bor_low;
    @(posedge clk) disable iff (rst)
      (brownout_enable && brownout_level_select == BOR_2V2 && !sup_s2_q[0]) |=> internal_reset;
  endproperty
  a_bor_low: assert property (p_bor_low) else $error("low threshold ignored");

  property p_bor_mid;
    @(posedge clk) disable iff (rst)
      (brownout_enable && brownout_level_select == BOR_2V6 && !sup_s2_q[1]) |=> internal_reset;
  endproperty
  a_bor_mid: assert property (p_bor_mid) else $error("middle threshold ignored");

  property p_bor_high;
    @(posedge clk) disable iff (rst)
      (brownout_enable && brownout_level_select == BOR_4V2 && !sup_s2_q[2]) |=> internal_reset;
  endproperty
  a_bor_high: assert property (p_bor_high) else $error("high threshold ignored");

  property p_wdt_pd_flags;
    @(posedge clk) disable iff (rst)
      (wdt_s && !por_s && in_powerdown) |=> {timeout_flag, powerdown_flag} == FLAGS_WDT_PD;
  endproperty
  a_wdt_pd_flags: assert property (p_wdt_pd_flags) else $error("watchdog sleep flags");

  property p_wdt_act_flags;
    @(posedge clk) disable iff (rst)
      (wdt_s && !por_s && !in_powerdown) |=> {timeout_flag, powerdown_flag} == FLAGS_WDT_ACT;
  endproperty
  a_wdt_act_flags: assert property (p_wdt_act_flags) else $error("watchdog run flags");

  property p_pin_pd_flags;
    @(posedge clk) disable iff (rst)
      (pin_fall && in_powerdown && !por_s && !wdt_s) |=>
        {timeout_flag, powerdown_flag} == FLAGS_PIN_PD;
  endproperty
  a_pin_pd_flags: assert property (p_pin_pd_flags) else $error("pin sleep flags");

  property p_pc_idle;
    @(posedge clk) disable iff (rst) !internal_reset |-> !pc_load;
  endproperty
  a_pc_idle: assert property (p_pc_idle) else $error("pc load outside reset");
endmodule // rdseq_top

// ### testbench/rdseq_supply_model.sv
`timescale 1ns/10ps
module rdseq_supply_model (
  input  wire logic [12:0] vdd_mv,
  input  wire logic        pin_hold,
  output logic             power_on_event,
  output logic             external_reset_pin,
  output logic [2:0]       supply_above_level
);
  // supply in millivolts; power-on detector trips below 1.5 V
  assign power_on_event = vdd_mv < 13'h5DC;
  // detectors at 2.2, 2.6 and 4.2 V
  assign supply_above_level = {vdd_mv > 13'h1068, vdd_mv > 13'hA28, vdd_mv > 13'h898};
  // pin only reads high once the supply is up
  assign external_reset_pin = !pin_hold && !power_on_event;
endmodule // rdseq_supply_model

// ### testbench/rdseq_top_bench.sv
`timescale 1ns/10ps
module rdseq_top_bench;
  import rdseq_pkg::*;
  localparam int STP = 1024;
  logic clk = 1'b0, rst = 1'b1, por, pin, wdt = 1'b0, wake = 1'b0, pd = 1'b0;
  logic [2:0] sup;
  logic [1:0] bsel = 2'h0, wsel = WAKE_DEFAULT;
  logic sco = 1'b1, pin_hold = 1'b1, ben = 1'b1, ir, pcl, tof, pdf, scr;
  logic [11:0] pcv;
  logic [12:0] vdd = 13'h0;
  int err_total = 0, n_tests = 0, cyc = 0;
  rdseq_top #(.POR_CYCLES(5*STP), .W00_CYCLES(STP), .W01_CYCLES(2*STP),
    .W10_CYCLES(3*STP), .W11_CYCLES(4*STP)) u_rdseq_top (.clk(clk), .rst(rst),
    .power_on_event(por), .external_reset_pin(pin), .watchdog_event(wdt),
    .wakeup_event(wake), .in_powerdown(pd), .supply_above_level(sup),
    .brownout_level_select(bsel), .brownout_enable(ben), .wake_delay_select(wsel),
    .sleep_clock_off_bit(sco), .internal_reset(ir), .pc_load(pcl), .pc_value(pcv),
    .timeout_flag(tof), .powerdown_flag(pdf), .sleep_clock_run(scr));
  rdseq_supply_model u_rdseq_supply_model (.vdd_mv(vdd), .pin_hold(pin_hold),
    .power_on_event(por), .external_reset_pin(pin), .supply_above_level(sup));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // reset still held shortly before n cycles, gone shortly after
  task automatic release_after(input int n);
    tick(n - 8);
    chk(ir, 1'b1, "released early");
    for (int k = 0; k < 20 && ir !== 1'b0; k++) tick(1);
    chk(ir, 1'b0, "not released");
    chk(pcl, 1'b0, "pc load after release");
  endtask
  task automatic t_por;
    tick(4);
    vdd = 13'hCE4;
    tick(3000);
    chk(ir, 1'b1, "counted before pin high");
    pin_hold = 1'b0;
    release_after(5*STP);
    chk({tof, pdf}, FLAGS_POR, "power-on flags");
    $display("power-on test done");
  endtask
  task automatic t_wdt(input logic p, input logic [1:0] c, input logic [1:0] f, input int n);
    pd = p;
    wsel = c;
    wdt = 1'b1;
    tick(1);
    wdt = 1'b0;
    tick(4);
    chk(pcl, 1'b1, "no pc load");
    chk(pcv, PC_TOP, "pc value");
    chk({tof, pdf}, f, "watchdog flags");
    release_after(n);
    pd = 1'b0;
    $display("watchdog test done");
  endtask
  task automatic t_restart;
    wsel = WAKE_DEFAULT;
    wake = 1'b1;
    tick(1);
    wake = 1'b0;
    tick(STP);
    wdt = 1'b1;
    tick(1);
    wdt = 1'b0;
    release_after(2*STP + 4);
    $display("restart test done");
  endtask
  task automatic t_pin(input logic p, input logic [1:0] f);
    pd = p;
    wsel = WAKE_DEFAULT;
    pin_hold = 1'b1;
    tick(4);
    chk(ir, 1'b1, "pin reset ignored");
    pin_hold = 1'b0;
    tick(1);
    chk({tof, pdf}, f, "pin flags");
    release_after(2*STP);
    pd = 1'b0;
    $display("pin test done");
  endtask
  task automatic t_brownout;
    logic [12:0] lo [4] = '{13'h7D0, 13'h960, 13'hBB8, 13'hBB8};
    logic [12:0] hi [4] = '{13'h960, 13'hBB8, 13'h1194, 13'h1194};
    for (int l = 0; l < 4; l++) begin
      bsel = l[1:0];
      vdd = lo[l];
      tick(300);
      chk(ir, 1'b1, "brown-out not held");
      vdd = hi[l];
      release_after(2*STP);
    end
    bsel = BOR_2V2;
    ben = 1'b0;
    vdd = 13'h7D0;
    tick(300);
    chk(ir, 1'b0, "brown-out while disabled");
    vdd = 13'hCE4;
    tick(4);
    ben = 1'b1;
    $display("brown-out test done");
  endtask
  task automatic t_sleep;
    sco = 1'b0;
    tick(2);
    chk(scr, 1'b1, "clock stopped");
    sco = 1'b1;
    tick(2);
    chk(scr, 1'b0, "clock kept");
    $display("sleep clock test done");
  endtask
  initial begin
    tick(8);
    rst = 1'b0;
    t_por();
    t_wdt(1'b0, 2'h1, FLAGS_WDT_ACT, 2*STP);
    t_wdt(1'b1, 2'h0, FLAGS_WDT_PD, STP);
    t_wdt(1'b1, 2'h2, FLAGS_WDT_PD, 3*STP);
    t_wdt(1'b1, 2'h3, FLAGS_WDT_PD, 4*STP);
    t_restart();
    t_pin(1'b0, FLAGS_WDT_ACT);
    t_pin(1'b1, FLAGS_PIN_PD);
    t_brownout();
    t_sleep();
    test_done();
  end
endmodule // rdseq_top_bench
